//--- verilog/ftsc_top.sv
`timescale 1ns/1ps
`include "ftsc_regs.svh"

// Notes on behaviour
// - each reset copies stored protect and option bytes into working registers.
// - key enable set lets the eight-byte backdoor key unlock security.
// - key entry only from secure user code, never from debug.
// - key enable clear disables backdoor; only mass erase plus blank check.
// - security field 1:0 means unsecured.
// - while secured, block debug and non-secure code access to RAM.
// - divider must be written before commands; otherwise command refused.
// - divider accepts only one write per reset.
// - divider write ignored while access error flag is set.
// - timing clock from bus clock and divider; pulses count timing periods.
// - byte program 9 timing cycles, burst byte 4.
// - page erase 4000 timing cycles, mass erase 20000.
// - array organised in pages of 512 bytes.
// - only five command codes valid; others raise access error.
// - writing 1 to buffer-empty flag launches the buffered command.
// - access error clears only on write 1; blocks new commands.
// - array write before divider write sets access error.
module ftsc_top
    import ftsc_pkg::*;
#(
    parameter int MASS_CYC = `FTSC_T_MASS,
    parameter int PAGE_CYC = `FTSC_T_PAGE
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic srst_i,
    // register port
    input wire ftsc_pkg::ftsc_addr_t reg_addr_i,
    input wire ftsc_pkg::ftsc_byte_t reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic reg_dbg_i,
    input wire logic reg_secure_src_i,
    output ftsc_pkg::ftsc_byte_t reg_rdata_o,
    // array write capture
    input wire logic arr_wr_i,
    input wire ftsc_pkg::ftsc_addr_t arr_addr_i,
    input wire ftsc_pkg::ftsc_byte_t arr_wdata_i,
    // nonvolatile load port
    output logic nv_rd_o,
    output ftsc_pkg::ftsc_addr_t nv_addr_o,
    input wire ftsc_pkg::ftsc_byte_t nv_rdata_i,
    // array engine
    output logic hv_on_o,
    output ftsc_pkg::ftsc_byte_t run_cmd_o,
    output ftsc_pkg::ftsc_addr_t run_addr_o,
    output ftsc_pkg::ftsc_byte_t run_data_o,
    output logic [6:0] run_page_o,
    input wire logic blank_ok_i,
    input wire logic prot_hit_i,
    // security
    input wire logic ram_req_i,
    output logic secured_o,
    output logic ram_block_o
);
    import ftsc_pkg::*;

    function automatic logic cmd_ok(input ftsc_byte_t c);
        cmd_ok = (c == `FTSC_CMD_BLANK) || (c == `FTSC_CMD_BYTE) ||
                 (c == `FTSC_CMD_BURST) || (c == `FTSC_CMD_PAGE) ||
                 (c == `FTSC_CMD_MASS);
    endfunction

    function automatic logic hit(input ftsc_addr_t a, input ftsc_addr_t o);
        hit = (a == o);
    endfunction

    ftsc_state_e st_r;
    logic [1:0] ld_step_r;
    ftsc_byte_t prot_r, opt_r;
    logic div_ld_r, pre8_r;
    logic [5:0] div_r;
    logic key_access_bit_r;
    logic cbef_r, ccf_r, pviol_r, accerr_r, blank_r;
    ftsc_byte_t cmd_r, data_r;
    ftsc_addr_t addr_r;
    logic [14:0] tcnt_r;
    logic tick;
    logic [1:0] key_step_r;
    logic [2:0] kin_idx_r;
    logic [7:0] key_ok_r;
    ftsc_byte_t key_in_r;
    logic key_take;
    logic key_match;
    logic unlocked_r;
    logic wr_div, wr_cfg, wr_stat, wr_cmd, wr_key;
    logic secure_sw;
    logic ctrl_touch;

    assign wr_div = reg_wr_i && hit(reg_addr_i, `FTSC_OFF_DIV);
    assign wr_cfg = reg_wr_i && hit(reg_addr_i, `FTSC_OFF_CFG);
    assign wr_stat = reg_wr_i && hit(reg_addr_i, `FTSC_OFF_STAT);
    assign wr_cmd = reg_wr_i && hit(reg_addr_i, `FTSC_OFF_CMD);
    assign wr_key = reg_wr_i &&
                    (reg_addr_i[15:3] == 13'(`FTSC_OFF_KEY0 >> 3));
    // entries from debug or from outside secure code never count
    assign key_take = wr_key && key_access_bit_r && opt_r[`FTSC_OPT_KEY_ENABLE_BIT]
                      && !reg_dbg_i && reg_secure_src_i;
    assign key_match = (nv_rdata_i == key_in_r);
    // fields 1:0 of the option byte: only 2'b10 is unsecured
    assign secure_sw = (opt_r[1:0] != 2'b10) && !unlocked_r;
    assign ctrl_touch = (reg_wr_i || reg_rd_i) &&
                        (reg_addr_i[15:4] == 12'h182) && !wr_stat;

    // ==========================================================
    // timing tick
    ftsc_tick_div u_div (
        .ref_clk_i(ref_clk_i),
        .srst_i(srst_i),
        .run_i(div_ld_r),
        .pre8_i(pre8_r),
        .div_i(div_r),
        .tick_o(tick)
    );

    // ==========================================================
    // reset load of working bytes, then idle
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            ld_step_r <= 2'd0;
            nv_rd_o <= 1'b0;
            nv_addr_o <= 16'h0000;
            prot_r <= 8'hff;
            opt_r <= 8'h00;
        end else if (st_r == FTSC_LOAD) begin
            ld_step_r <= ld_step_r + 2'd1;
            nv_rd_o <= (ld_step_r == 2'd0) || (ld_step_r == 2'd1);
            nv_addr_o <= (ld_step_r == 2'd0) ? `FTSC_NV_PROT : `FTSC_NV_OPT;
            if (ld_step_r == 2'd2) begin
                prot_r <= nv_rdata_i;
            end
            if (ld_step_r == 2'd3) begin
                opt_r <= nv_rdata_i;
            end
        end else if (key_step_r == 2'd1) begin
            // fetch the stored byte that pairs with the entry
            nv_rd_o <= 1'b1;
            nv_addr_o <= `FTSC_NV_KEY + {13'h0, kin_idx_r};
        end else begin
            nv_rd_o <= 1'b0;
            // debug may rewrite protection to allow erasing
            if (reg_wr_i && reg_dbg_i && hit(reg_addr_i, `FTSC_OFF_PROT)) begin
                prot_r <= {reg_wdata_i[7:3], 3'b000};
            end
        end
    end

    // ==========================================================
    // divider: one write per reset, not while access error
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            div_ld_r <= 1'b0;
            pre8_r <= 1'b0;
            div_r <= 6'h00;
        end else if (wr_div && !div_ld_r && !accerr_r) begin
            div_ld_r <= 1'b1;
            pre8_r <= reg_wdata_i[`FTSC_DIV_PRE8];
            div_r <= reg_wdata_i[5:0];
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            key_access_bit_r <= 1'b0;
        end else if (wr_cfg && st_r == FTSC_IDLE) begin
            key_access_bit_r <= reg_wdata_i[`FTSC_CFG_KEY_ACCESS_BIT];
        end
    end

    // ==========================================================
    // backdoor key: each entry compared with its stored byte
    // offset 7 closes an attempt, so software enters it last;
    // all eight bytes must match, not only the closing one
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            key_step_r <= 2'd0;
            kin_idx_r <= 3'd0;
            key_in_r <= 8'h00;
            key_ok_r <= 8'h00;
            unlocked_r <= 1'b0;
        end else begin
            if (key_take) begin
                kin_idx_r <= reg_addr_i[2:0];
                key_in_r <= reg_wdata_i;
                key_step_r <= 2'd1;
            end else if (key_step_r != 2'd0) begin
                key_step_r <= key_step_r + 2'd1;
            end
            // stored byte stands at the third step; an entry taken
            // sooner restarts the fetch and its byte is not judged
            if (!key_take && key_step_r == 2'd3) begin
                if (kin_idx_r == 3'd7) begin
                    unlocked_r <= unlocked_r ||
                                  (&key_ok_r[6:0] && key_match);
                    key_ok_r <= 8'h00;
                end else begin
                    key_ok_r[kin_idx_r] <= key_match;
                end
            end
            if (st_r == FTSC_RUN && cmd_r == `FTSC_CMD_BLANK
                && tcnt_r == 15'd0 && tick && blank_ok_i) begin
                unlocked_r <= 1'b1;
            end
        end
    end

    // ==========================================================
    // command sequencer
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            st_r <= FTSC_LOAD;
            cbef_r <= 1'b1;
            ccf_r <= 1'b1;
            pviol_r <= 1'b0;
            accerr_r <= 1'b0;
            blank_r <= 1'b0;
            cmd_r <= 8'h00;
            addr_r <= 16'h0000;
            data_r <= 8'h00;
            tcnt_r <= 15'd0;
        end else begin
            // data_r holds array data only; key entries keep their own
            if (wr_stat && reg_wdata_i[`FTSC_ST_ACCERR]) begin
                accerr_r <= 1'b0;
            end
            if (wr_stat && reg_wdata_i[`FTSC_ST_PVIOL]) begin
                pviol_r <= 1'b0;
            end
            unique case (st_r)
                FTSC_LOAD: begin
                    if (ld_step_r == 2'd3) begin
                        st_r <= FTSC_IDLE;
                    end
                end
                FTSC_IDLE: begin
                    if (arr_wr_i) begin
                        if (!div_ld_r || accerr_r) begin
                            accerr_r <= 1'b1;
                        end else begin
                            addr_r <= arr_addr_i;
                            data_r <= arr_wdata_i;
                            st_r <= FTSC_ADDR;
                        end
                    end
                end
                FTSC_ADDR: begin
                    if (arr_wr_i || (reg_wr_i && !wr_cmd)) begin
                        accerr_r <= 1'b1;
                        st_r <= FTSC_IDLE;
                    end else if (wr_cmd) begin
                        if (!cmd_ok(reg_wdata_i) || (reg_dbg_i && secure_sw
                            && reg_wdata_i != `FTSC_CMD_MASS
                            && reg_wdata_i != `FTSC_CMD_BLANK)) begin
                            accerr_r <= 1'b1;
                            st_r <= FTSC_IDLE;
                        end else begin
                            cmd_r <= reg_wdata_i;
                            st_r <= FTSC_CMDW;
                        end
                    end
                end
                FTSC_CMDW: begin
                    if (wr_stat && reg_wdata_i[`FTSC_ST_CBEF]) begin
                        if (prot_hit_i) begin
                            pviol_r <= 1'b1;
                            st_r <= FTSC_IDLE;
                        end else begin
                            cbef_r <= 1'b1;
                            ccf_r <= 1'b0;
                            blank_r <= 1'b0;
                            unique case (cmd_r)
                                `FTSC_CMD_BYTE: tcnt_r <= 15'(`FTSC_T_BYTE - 1);
                                `FTSC_CMD_BURST: tcnt_r <= 15'(`FTSC_T_BURST - 1);
                                `FTSC_CMD_PAGE: tcnt_r <= 15'(PAGE_CYC - 1);
                                `FTSC_CMD_MASS: tcnt_r <= 15'(MASS_CYC - 1);
                                default: tcnt_r <= 15'(`FTSC_T_BLANK - 1);
                            endcase
                            st_r <= FTSC_RUN;
                        end
                    end else if (wr_stat || ctrl_touch || arr_wr_i) begin
                        accerr_r <= 1'b1;
                        st_r <= FTSC_IDLE;
                    end
                end
                FTSC_RUN: begin
                    if (tick) begin
                        if (tcnt_r == 15'd0) begin
                            ccf_r <= 1'b1;
                            blank_r <= (cmd_r == `FTSC_CMD_BLANK) && blank_ok_i;
                            st_r <= FTSC_IDLE;
                        end else begin
                            tcnt_r <= tcnt_r - 15'd1;
                        end
                    end
                end
                default: st_r <= FTSC_IDLE;
            endcase
        end
    end

    // ==========================================================
    // outputs and read data
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            hv_on_o <= 1'b0;
            run_cmd_o <= 8'h00;
            run_addr_o <= 16'h0000;
            run_data_o <= 8'h00;
            run_page_o <= 7'h00;
            secured_o <= 1'b1;
            ram_block_o <= 1'b0;
        end else begin
            hv_on_o <= (st_r == FTSC_RUN);
            run_cmd_o <= cmd_r;
            run_addr_o <= addr_r;
            run_data_o <= data_r;
            run_page_o <= 7'(addr_r / `FTSC_PAGE_BYTES);
            secured_o <= secure_sw;
            ram_block_o <= secure_sw && ram_req_i
                           && (reg_dbg_i || !reg_secure_src_i);
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            unique case (reg_addr_i)
                `FTSC_OFF_DIV: reg_rdata_o <= {div_ld_r, pre8_r, div_r};
                `FTSC_OFF_OPT: reg_rdata_o <= {opt_r[7:6], 4'h0, opt_r[1:0]};
                `FTSC_OFF_CFG: reg_rdata_o <= {2'b00, key_access_bit_r, 5'h00};
                `FTSC_OFF_PROT: reg_rdata_o <= prot_r;
                `FTSC_OFF_STAT: reg_rdata_o <= {cbef_r, ccf_r, pviol_r,
                                                accerr_r, 1'b0, blank_r, 2'b00};
                `FTSC_OFF_SECST: reg_rdata_o <= {7'h00, secure_sw};
                default: reg_rdata_o <= 8'h00;
            endcase
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end
endmodule

//--- verilog/ftsc_regs.svh
`ifndef FTSC_REGS_SVH
`define FTSC_REGS_SVH

// ==========================================================
// register offsets
`define FTSC_OFF_DIV 16'h1820
`define FTSC_OFF_OPT 16'h1821
`define FTSC_OFF_CFG 16'h1823
`define FTSC_OFF_PROT 16'h1824
`define FTSC_OFF_STAT 16'h1825
`define FTSC_OFF_CMD 16'h1826
// own choice: backdoor key entry, one byte per offset 0..7
`define FTSC_OFF_KEY0 16'h1828
`define FTSC_OFF_SECST 16'h1830

// ==========================================================
// nonvolatile locations
`define FTSC_NV_KEY 16'hffb0
`define FTSC_NV_PROT 16'hffbd
`define FTSC_NV_OPT 16'hffbf

// ==========================================================
// field positions
`define FTSC_DIV_LD 7
`define FTSC_DIV_PRE8 6
`define FTSC_OPT_KEY_ENABLE_BIT 7
`define FTSC_CFG_KEY_ACCESS_BIT 5
`define FTSC_ST_CBEF 7
`define FTSC_ST_CCF 6
`define FTSC_ST_PVIOL 5
`define FTSC_ST_ACCERR 4
`define FTSC_ST_BLANK 2

// ==========================================================
// command codes
`define FTSC_CMD_BLANK 8'h05
`define FTSC_CMD_BYTE 8'h20
`define FTSC_CMD_BURST 8'h25
`define FTSC_CMD_PAGE 8'h40
`define FTSC_CMD_MASS 8'h41

// ==========================================================
// timing counts in timing-clock periods, page size in bytes, prescale ratio
`define FTSC_T_BYTE 9
`define FTSC_T_BURST 4
`define FTSC_T_PAGE 4000
`define FTSC_T_MASS 20000
`define FTSC_T_BLANK 1
`define FTSC_PAGE_BYTES 512
`define FTSC_PRE8 8

`endif

//--- verilog/ftsc_pkg.sv
package ftsc_pkg;
    typedef enum logic [2:0] {
        FTSC_IDLE = 3'b000,
        FTSC_ADDR = 3'b001,
        FTSC_CMDW = 3'b010,
        FTSC_RUN = 3'b011,
        FTSC_LOAD = 3'b100
    } ftsc_state_e;
    typedef logic [7:0] ftsc_byte_t;
    typedef logic [15:0] ftsc_addr_t;
endpackage

//--- verilog/ftsc_tick_div.sv
`timescale 1ns/1ps
`include "ftsc_regs.svh"

// ==========================================================
// timing clock enable: bus clock / (div+1), optional /8 first
module ftsc_tick_div (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic srst_i,
    // setting
    input wire logic run_i,
    input wire logic pre8_i,
    input wire logic [5:0] div_i,
    // timing tick
    output logic tick_o
);
    logic [2:0] pre_r;
    logic [5:0] cnt_r;
    logic pre_tick;

    assign pre_tick = !pre8_i || (pre_r == 3'h7);

    always_ff @(posedge ref_clk_i) begin
        if (srst_i || !run_i) begin
            pre_r <= 3'h0;
        end else begin
            pre_r <= pre_r + 3'h1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i || !run_i) begin
            cnt_r <= 6'h0;
            tick_o <= 1'b0;
        end else begin
            tick_o <= 1'b0;
            if (pre_tick) begin
                if (cnt_r >= div_i) begin
                    cnt_r <= 6'h0;
                    tick_o <= 1'b1;
                end else begin
                    cnt_r <= cnt_r + 6'h1;
                end
            end
        end
    end
endmodule

//--- verification/ftsc_asserts.sv
`timescale 1ns/1ps
// ==========================================================
// checker on the top ports
module ftsc_asserts
    import ftsc_pkg::*;
#(
    parameter int MASS_CYC = 20000
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic srst_i,
    // register port
    input wire logic reg_wr_i,
    input wire logic reg_dbg_i,
    input wire logic reg_secure_src_i,
    input wire ftsc_pkg::ftsc_addr_t reg_addr_i,
    // nonvolatile load
    input wire logic nv_rd_o,
    input wire ftsc_pkg::ftsc_addr_t nv_addr_o,
    // array engine
    input wire logic hv_on_o,
    input wire ftsc_pkg::ftsc_byte_t run_cmd_o,
    input wire ftsc_pkg::ftsc_addr_t run_addr_o,
    input wire logic [6:0] run_page_o,
    // security
    input wire logic ram_req_i,
    input wire logic secured_o,
    input wire logic ram_block_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);
    logic [23:0] hv_cnt_r;
    // longest pulse: mass erase at the slowest tick, /64 and /8
    always_ff @(posedge ref_clk_i) begin
        if (srst_i || !hv_on_o) begin
            hv_cnt_r <= 24'h000000;
        end else begin
            hv_cnt_r <= hv_cnt_r + 24'h000001;
        end
    end
    nv_addr_a: assert property (nv_rd_o |->
        (nv_addr_o == 16'hffbd || nv_addr_o == 16'hffbf ||
         nv_addr_o[15:3] == 13'h1ff6)) else $error("bad load address");
    nv_first_a: assert property ($fell(srst_i) |->
        ##[1:4] (nv_rd_o && nv_addr_o == 16'hffbd))
        else $error("protect byte not loaded");
    hv_start_a: assert property ($rose(hv_on_o) |->
        $past(reg_wr_i, 2) && $past(reg_addr_i, 2) == 16'h1825)
        else $error("pulse without launch");
    ram_blk_a: assert property (ram_block_o |->
        secured_o && $past(ram_req_i)) else $error("ram blocked");
    ram_why_a: assert property (secured_o &&
        $past(ram_req_i && (reg_dbg_i || !reg_secure_src_i)) |-> ram_block_o)
        else $error("ram access left open");
    run_hold_a: assert property (hv_on_o && $past(hv_on_o) |->
        $stable(run_cmd_o) && $stable(run_addr_o))
        else $error("command moved while running");
    run_page_a: assert property (hv_on_o |->
        run_page_o == run_addr_o[15:9]) else $error("page number wrong");
    hv_bound_a: assert property (hv_cnt_r <= MASS_CYC * 512 + 8)
        else $error("pulse too long");
    cover property ($rose(hv_on_o));
    cover property (ram_block_o);
    cover property ($fell(secured_o));
endmodule

//--- verification/ftsc_nv_model.sv
`timescale 1ns/1ps
// ==========================================================
// stored byte area answering the reset-time loads
module ftsc_nv_model
    import ftsc_pkg::*;
(
    // clock
    input wire logic ref_clk_i,
    // load port
    input wire logic nv_rd_i,
    input wire ftsc_pkg::ftsc_addr_t nv_addr_i,
    input wire ftsc_pkg::ftsc_byte_t prot_i,
    input wire ftsc_pkg::ftsc_byte_t opt_i,
    output ftsc_pkg::ftsc_byte_t nv_rdata_o
);
    initial nv_rdata_o = 8'h00;
    // off-cycle data flips so a late sample reads wrong
    always @(posedge ref_clk_i) begin
        if (nv_rd_i) begin
            case (nv_addr_i)
                16'hffbd: nv_rdata_o <= prot_i;
                16'hffbf: nv_rdata_o <= opt_i;
                default: nv_rdata_o <= nv_addr_i[7:0] ^ 8'h5a;
            endcase
        end else begin
            nv_rdata_o <= ~nv_rdata_o;
        end
    end
endmodule

//--- verification/test_flash_timing_security_ctrl.sv
`timescale 1ns/1ps
// ==========================================================
// bench
module test_flash_timing_security_ctrl;
    import ftsc_pkg::*;
    logic ref_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, reg_dbg_i = 1'b0;
    logic arr_wr_i = 1'b0, ram_req_i = 1'b0, blank_ok_i = 1'b1;
    logic sec_src = 1'b1;
    logic nv_rd_o, hv_on_o, secured_o, ram_block_o;
    logic [6:0] run_page_o;
    ftsc_addr_t reg_addr_i = 16'h0000, arr_addr_i = 16'hc204;
    ftsc_addr_t nv_addr_o, run_addr_o;
    ftsc_byte_t reg_wdata_i = 8'h00, arr_wdata_i = 8'h3c, rv;
    ftsc_byte_t nv_opt = 8'h80, nv_prot = 8'hf8;
    ftsc_byte_t reg_rdata_o, nv_rdata_i, run_cmd_o, run_data_o;
    int err_count = 0, num_checks = 0, len;
    always #2 ref_clk_i = ~ref_clk_i;
    ftsc_top #(.MASS_CYC(20), .PAGE_CYC(10)) dut (.ref_clk_i(ref_clk_i),
        .srst_i(srst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_dbg_i(reg_dbg_i),
        .reg_secure_src_i(sec_src), .reg_rdata_o(reg_rdata_o),
        .arr_wr_i(arr_wr_i), .arr_addr_i(arr_addr_i),
        .arr_wdata_i(arr_wdata_i), .nv_rd_o(nv_rd_o), .nv_addr_o(nv_addr_o),
        .nv_rdata_i(nv_rdata_i), .hv_on_o(hv_on_o), .run_cmd_o(run_cmd_o),
        .run_addr_o(run_addr_o), .run_data_o(run_data_o),
        .run_page_o(run_page_o), .blank_ok_i(blank_ok_i),
        .prot_hit_i(1'b0), .ram_req_i(ram_req_i), .secured_o(secured_o),
        .ram_block_o(ram_block_o));
    ftsc_nv_model u_nv (.ref_clk_i(ref_clk_i), .nv_rd_i(nv_rd_o),
        .nv_addr_i(nv_addr_o), .prot_i(nv_prot), .opt_i(nv_opt),
        .nv_rdata_o(nv_rdata_i));
    task check(input ftsc_byte_t seen, input ftsc_byte_t exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task wr(input ftsc_addr_t a, input ftsc_byte_t d);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task rd(input ftsc_addr_t a);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b0;
        #1;
        rv = reg_rdata_o;
    endtask
    task aw;
        @(posedge ref_clk_i);
        arr_wr_i <= 1'b1;
        @(posedge ref_clk_i);
        arr_wr_i <= 1'b0;
    endtask
    task do_reset(input logic sec);
        srst_i <= 1'b1;
        repeat (5) @(posedge ref_clk_i);
        srst_i <= 1'b0;
        repeat (6) @(posedge ref_clk_i);
        rd(16'h1824);
        check(rv, nv_prot);
        rd(16'h1821);
        check(rv, nv_opt);
        check({7'h00, secured_o}, {7'h00, sec});
    endtask
    // length of the high-voltage pulse in bus cycles
    task run_cmd(input ftsc_byte_t code);
        int w;
        aw();
        wr(16'h1826, code);
        wr(16'h1825, 8'h80);
        w = 0;
        len = 0;
        while (hv_on_o !== 1'b1 && w < 10) begin
            @(posedge ref_clk_i);
            w++;
        end
        while (hv_on_o === 1'b1 && len < 2000) begin
            @(posedge ref_clk_i);
            len++;
        end
        rd(16'h1825);
        check(rv & 8'hc0, 8'hc0);
        check(run_cmd_o, code);
        check(run_data_o, arr_wdata_i);
        check({1'b0, run_page_o}, 8'h61);
    endtask
    // tick phase at launch is free, so allow one tick either way
    function automatic ftsc_byte_t win(input int n, input int p);
        return (len >= (n - 1) * p && len <= (n + 1) * p + 4) ? 8'h01 : 8'h00;
    endfunction
    task t_divider;
        aw();
        rd(16'h1825);
        check(rv & 8'h10, 8'h10);
        wr(16'h1820, 8'h03);
        rd(16'h1820);
        check(rv, 8'h00);
        wr(16'h1825, 8'h10);
        rd(16'h1825);
        check(rv & 8'h10, 8'h00);
        wr(16'h1820, 8'h03);
        rd(16'h1820);
        check(rv, 8'h83);
        wr(16'h1820, 8'h05);
        rd(16'h1820);
        check(rv, 8'h83);
    endtask
    task t_ram;
        ram_req_i <= 1'b1;
        reg_dbg_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        #1;
        check({7'h00, ram_block_o}, 8'h01);
        reg_dbg_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        #1;
        check({7'h00, ram_block_o}, 8'h00);
        sec_src <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        #1;
        check({7'h00, ram_block_o}, 8'h01);
        ram_req_i <= 1'b0;
        sec_src <= 1'b1;
    endtask
    task t_cmds;
        run_cmd(8'h20);
        check(win(9, 4), 8'h01);
        run_cmd(8'h25);
        check(win(4, 4), 8'h01);
        run_cmd(8'h40);
        check(win(10, 4), 8'h01);
        run_cmd(8'h41);
        check(win(20, 4), 8'h01);
        aw();
        wr(16'h1826, 8'h33);
        rd(16'h1825);
        check(rv & 8'h10, 8'h10);
        wr(16'h1825, 8'h10);
        reg_dbg_i <= 1'b1;
        aw();
        wr(16'h1826, 8'h20);
        rd(16'h1825);
        check(rv & 8'h10, 8'h10);
        reg_dbg_i <= 1'b0;
        wr(16'h1825, 8'h10);
        run_cmd(8'h05);
        check(win(1, 4), 8'h01);
        rd(16'h1825);
        check(rv & 8'h04, 8'h04);
        check({7'h00, secured_o}, 8'h00);
    endtask
    // all eight entries; the stored byte at offset i is (b0+i)^5a
    task key_all(input ftsc_byte_t flip);
        for (int i = 0; i < 8; i++) begin
            wr(16'h1828 + 16'(i), (8'hb0 + 8'(i)) ^ 8'h5a ^ flip);
            repeat (5) @(posedge ref_clk_i);
        end
    endtask
    task t_key;
        nv_opt <= 8'h80;
        do_reset(1'b1);
        wr(16'h1823, 8'h20);
        reg_dbg_i <= 1'b1;
        key_all(8'h00);
        check({7'h00, secured_o}, 8'h01);
        reg_dbg_i <= 1'b0;
        key_all(8'h01);
        check({7'h00, secured_o}, 8'h01);
        key_all(8'h00);
        check({7'h00, secured_o}, 8'h00);
        nv_opt <= 8'h00;
        do_reset(1'b1);
        wr(16'h1823, 8'h20);
        key_all(8'h00);
        check({7'h00, secured_o}, 8'h01);
    endtask
    task t_rereset;
        nv_opt <= 8'h02;
        do_reset(1'b0);
        wr(16'h1820, 8'h43);
        rd(16'h1820);
        check(rv, 8'hc3);
        run_cmd(8'h20);
        check(win(9, 32), 8'h01);
    endtask
    initial begin
        do_reset(1'b1);
        t_divider();
        t_ram();
        t_cmds();
        t_key();
        t_rereset();
        close_out();
    end
    initial begin
        #100000;
        err_count++;
        close_out();
    end
endmodule
bind ftsc_top ftsc_asserts #(.MASS_CYC(MASS_CYC)) u_chk (
    .ref_clk_i(ref_clk_i), .srst_i(srst_i), .reg_wr_i(reg_wr_i),
    .reg_dbg_i(reg_dbg_i), .reg_secure_src_i(reg_secure_src_i),
    .reg_addr_i(reg_addr_i), .nv_rd_o(nv_rd_o),
    .nv_addr_o(nv_addr_o), .hv_on_o(hv_on_o), .run_cmd_o(run_cmd_o),
    .run_addr_o(run_addr_o), .run_page_o(run_page_o),
    .ram_req_i(ram_req_i), .secured_o(secured_o),
    .ram_block_o(ram_block_o));
